/* rtl/custom_b_regs_pkg.sv */
// package: register map, field layout, reset values and bus codes of the
// custom-b monitor and reference predivide register bank.
// assumes a 32-bit axi4-lite bus, one aligned word per register index.
package custom_b_regs_pkg;

  // register indices; byte address is four times the index
  localparam logic [7:0] LOWER_LSBS_IDX = 8'h75;
  localparam logic [7:0] LOWER_MSBS_IDX = 8'h76;
  localparam logic [7:0] UPPER_LSBS_IDX = 8'h77;
  localparam logic [7:0] UPPER_MSBS_IDX = 8'h78;
  localparam logic [7:0] CYCLES_IDX     = 8'h79;
  localparam logic [7:0] QUARTER_IDX    = 8'h7A;
  localparam logic [7:0] PREDIV_IDX     = 8'h7E;

  // field layout
  localparam int QUARTER_BIT = 0;
  localparam int PREDIV_LSB  = 0;
  localparam int PREDIV_W    = 4;
  localparam int WORD_LSB    = 2;

  // values after reset
  localparam logic [7:0] BYTE_RESET   = 8'h00;
  localparam logic [3:0] PREDIV_RESET = 4'h0;

  // predivide codes
  localparam logic [3:0] PREDIV_MAX_INT = 4'h7;
  localparam logic [3:0] PREDIV_ONE_HALF = 4'hA;
  localparam logic [3:0] PREDIV_TWO_HALF = 4'hC;

  // axi response codes
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

endpackage : custom_b_regs_pkg

/* rtl/prediv_decode.sv */
// predivide decoder: turns the 4-bit ratio code into twice the ratio.
// assumes the code comes from a register on the same clock.
`timescale 1ns/1ps
`default_nettype none
module prediv_decode
  import custom_b_regs_pkg::*;
(
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic [3:0] code,
  output logic      [4:0] ratio_x2,
  output logic            code_legal
);

  logic [4:0] next_ratio_x2;
  logic       next_code_legal;

  // ratio kept in half steps so 1.5 and 2.5 stay exact
  always_comb begin
    next_ratio_x2   = 5'h02;
    next_code_legal = 1'b1;
    if (code <= PREDIV_MAX_INT) begin
      next_ratio_x2 = {code, 1'b0} + 5'h02;
    end else if (code == PREDIV_ONE_HALF) begin
      next_ratio_x2 = 5'h03;
    end else if (code == PREDIV_TWO_HALF) begin
      next_ratio_x2 = 5'h05;
    end else begin
      // reserved codes fall back to divide by one and are flagged
      next_code_legal = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ratio_x2   <= 5'h02;
      code_legal <= 1'b1;
    end else begin
      ratio_x2   <= next_ratio_x2;
      code_legal <= next_code_legal;
    end
  end

endmodule : prediv_decode
`default_nettype wire

/* rtl/custom_b_monitor_regs.sv */
// custom-b frequency monitor limits, cycle count, divide-by-four enable
// and reference predivide ratio, reached over an axi4-lite slave.
// assumes a master that keeps at most one write and one read under way.
`timescale 1ns/1ps
`default_nettype none
module custom_b_monitor_regs
  import custom_b_regs_pkg::*;
#(
  parameter int ADDR_W = 12
)(
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic [2:0]        s_axi_awprot,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic [2:0]        s_axi_arprot,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  output logic [15:0]            custom_b_upper_limit,
  output logic [15:0]            custom_b_lower_limit,
  output logic [8:0]             custom_b_monitor_cycles,
  output logic                   custom_b_monitor_quarter,
  output logic [10:0]            custom_b_window_refcycles,
  output logic [4:0]             prediv_ratio_x2,
  output logic                   prediv_code_legal
);

  generate
    if (ADDR_W < 9 || ADDR_W > 32) begin : g_bad_addr_w
      $error("ADDR_W must lie between 9 and 32");
    end
  endgenerate

  function automatic logic [7:0] word_index(input logic [ADDR_W-1:0] addr);
    word_index = 8'(addr >> WORD_LSB);
  endfunction : word_index

  function automatic logic is_mapped(input logic [7:0] idx, input logic [ADDR_W-1:0] addr);
    logic upper_zero;
    upper_zero = ((addr >> WORD_LSB) >> 8) == '0;
    is_mapped  = upper_zero && (idx == LOWER_LSBS_IDX || idx == LOWER_MSBS_IDX ||
                 idx == UPPER_LSBS_IDX || idx == UPPER_MSBS_IDX ||
                 idx == CYCLES_IDX || idx == QUARTER_IDX || idx == PREDIV_IDX);
  endfunction : is_mapped

  ////////////////////////////////////////////////////////////////////////////
  // write channel

  logic              aw_full;
  logic [ADDR_W-1:0] aw_addr_q;
  logic              w_full;
  logic [7:0]        w_byte_q;
  logic              w_strb_q;
  logic              do_write;
  logic [7:0]        wr_idx;
  logic              next_aw_full;
  logic [ADDR_W-1:0] next_aw_addr_q;
  logic              next_w_full;
  logic [7:0]        next_w_byte_q;
  logic              next_w_strb_q;
  logic              next_bvalid;
  logic [1:0]        next_bresp;

  logic [7:0] lower_lsbs;
  logic [7:0] lower_msbs;
  logic [7:0] upper_lsbs;
  logic [7:0] upper_msbs;
  logic [7:0] cycles_m1;
  logic       quarter;
  logic [3:0] prediv_code;
  logic [7:0] next_lower_lsbs;
  logic [7:0] next_lower_msbs;
  logic [7:0] next_upper_lsbs;
  logic [7:0] next_upper_msbs;
  logic [7:0] next_cycles_m1;
  logic       next_quarter;
  logic [3:0] next_prediv_code;

  assign wr_idx   = word_index(aw_addr_q);
  // address and data are taken in either order; commit once both are held
  assign do_write = aw_full && w_full && !s_axi_bvalid;

  always_comb begin
    next_aw_full     = aw_full;
    next_aw_addr_q   = aw_addr_q;
    next_w_full      = w_full;
    next_w_byte_q    = w_byte_q;
    next_w_strb_q    = w_strb_q;
    next_bvalid      = s_axi_bvalid;
    next_bresp       = s_axi_bresp;
    next_lower_lsbs  = lower_lsbs;
    next_lower_msbs  = lower_msbs;
    next_upper_lsbs  = upper_lsbs;
    next_upper_msbs  = upper_msbs;
    next_cycles_m1   = cycles_m1;
    next_quarter     = quarter;
    next_prediv_code = prediv_code;
    if (s_axi_bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_full   = 1'b1;
      next_aw_addr_q = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_full   = 1'b1;
      next_w_byte_q = s_axi_wdata[7:0];
      next_w_strb_q = s_axi_wstrb[0];
    end
    if (do_write) begin
      next_aw_full = 1'b0;
      next_w_full  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = is_mapped(wr_idx, aw_addr_q) ? RESP_OKAY : RESP_DECERR;
      if (w_strb_q && is_mapped(wr_idx, aw_addr_q)) begin
        unique case (wr_idx)
          LOWER_LSBS_IDX: next_lower_lsbs = w_byte_q;
          LOWER_MSBS_IDX: next_lower_msbs = w_byte_q;
          UPPER_LSBS_IDX: next_upper_lsbs = w_byte_q;
          UPPER_MSBS_IDX: next_upper_msbs = w_byte_q;
          CYCLES_IDX:     next_cycles_m1  = w_byte_q;
          // reserved upper bits are dropped, not stored
          QUARTER_IDX:    next_quarter     = w_byte_q[QUARTER_BIT];
          PREDIV_IDX:     next_prediv_code = w_byte_q[PREDIV_LSB +: PREDIV_W];
          default:        next_quarter     = quarter;
        endcase
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full       <= 1'b0;
      aw_addr_q     <= '0;
      w_full        <= 1'b0;
      w_byte_q      <= BYTE_RESET;
      w_strb_q      <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
      lower_lsbs    <= BYTE_RESET;
      lower_msbs    <= BYTE_RESET;
      upper_lsbs    <= BYTE_RESET;
      upper_msbs    <= BYTE_RESET;
      cycles_m1     <= BYTE_RESET;
      quarter       <= 1'b0;
      prediv_code   <= PREDIV_RESET;
    end else begin
      aw_full       <= next_aw_full;
      aw_addr_q     <= next_aw_addr_q;
      w_full        <= next_w_full;
      w_byte_q      <= next_w_byte_q;
      w_strb_q      <= next_w_strb_q;
      s_axi_awready <= !next_aw_full;
      s_axi_wready  <= !next_w_full;
      s_axi_bvalid  <= next_bvalid;
      s_axi_bresp   <= next_bresp;
      lower_lsbs    <= next_lower_lsbs;
      lower_msbs    <= next_lower_msbs;
      upper_lsbs    <= next_upper_lsbs;
      upper_msbs    <= next_upper_msbs;
      cycles_m1     <= next_cycles_m1;
      quarter       <= next_quarter;
      prediv_code   <= next_prediv_code;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read channel

  logic [7:0]  rd_idx;
  logic [31:0] next_rdata;
  logic [1:0]  next_rresp;
  logic        next_rvalid;
  logic        next_arready;

  assign rd_idx = word_index(s_axi_araddr);

  always_comb begin
    next_rdata   = s_axi_rdata;
    next_rresp   = s_axi_rresp;
    next_rvalid  = s_axi_rvalid;
    next_arready = s_axi_arready;
    if (s_axi_rvalid && s_axi_rready) begin
      next_rvalid  = 1'b0;
      next_arready = 1'b1;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      next_rvalid  = 1'b1;
      next_arready = 1'b0;
      next_rdata   = 32'h0000_0000;
      next_rresp   = is_mapped(rd_idx, s_axi_araddr) ? RESP_OKAY : RESP_DECERR;
      if (is_mapped(rd_idx, s_axi_araddr)) begin
        unique case (rd_idx)
          LOWER_LSBS_IDX: next_rdata[7:0] = lower_lsbs;
          LOWER_MSBS_IDX: next_rdata[7:0] = lower_msbs;
          UPPER_LSBS_IDX: next_rdata[7:0] = upper_lsbs;
          UPPER_MSBS_IDX: next_rdata[7:0] = upper_msbs;
          CYCLES_IDX:     next_rdata[7:0] = cycles_m1;
          QUARTER_IDX:    next_rdata[QUARTER_BIT] = quarter;
          PREDIV_IDX:     next_rdata[PREDIV_LSB +: PREDIV_W] = prediv_code;
          default:        next_rdata = 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OKAY;
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b0;
    end else begin
      s_axi_rdata   <= next_rdata;
      s_axi_rresp   <= next_rresp;
      s_axi_rvalid  <= next_rvalid;
      s_axi_arready <= next_arready | (!next_rvalid);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // monitor-facing outputs

  logic [8:0]  next_monitor_cycles;
  logic [10:0] next_window;

  assign custom_b_upper_limit     = {upper_msbs, upper_lsbs};
  assign custom_b_lower_limit     = {lower_msbs, lower_lsbs};
  assign custom_b_monitor_quarter = quarter;

  always_comb begin
    next_monitor_cycles = {1'b0, cycles_m1} + 9'h001;
    // a quartered reference spans four input cycles per counted cycle
    next_window = quarter ? {custom_b_monitor_cycles, 2'b00}
                          : {2'b00, custom_b_monitor_cycles};
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      custom_b_monitor_cycles   <= 9'h001;
      custom_b_window_refcycles <= 11'h001;
    end else begin
      custom_b_monitor_cycles   <= next_monitor_cycles;
      custom_b_window_refcycles <= next_window;
    end
  end

  prediv_decode u_prediv_decode (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .code       (prediv_code),
    .ratio_x2   (prediv_ratio_x2),
    .code_legal (prediv_code_legal)
  );

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_upper_lsbs;
    do_write && w_strb_q && wr_idx == UPPER_LSBS_IDX && is_mapped(wr_idx, aw_addr_q)
      |=> custom_b_upper_limit[7:0] == $past(w_byte_q);
  endproperty
  a_upper_lsbs: assert property (p_upper_lsbs) else $error("upper lsbs not taken");

  property p_upper_msbs;
    do_write && w_strb_q && wr_idx == UPPER_MSBS_IDX && is_mapped(wr_idx, aw_addr_q)
      |=> custom_b_upper_limit[15:8] == $past(w_byte_q) && $stable(custom_b_upper_limit[7:0]);
  endproperty
  a_upper_msbs: assert property (p_upper_msbs) else $error("upper msbs not taken");

  property p_lower_limit;
    do_write && w_strb_q && wr_idx == LOWER_MSBS_IDX && is_mapped(wr_idx, aw_addr_q)
      |=> custom_b_lower_limit[15:8] == $past(w_byte_q);
  endproperty
  a_lower_limit: assert property (p_lower_limit) else $error("lower msbs not taken");

  property p_cycles;
    do_write && w_strb_q && wr_idx == CYCLES_IDX && is_mapped(wr_idx, aw_addr_q)
      |-> ##2 custom_b_monitor_cycles == {1'b0, $past(w_byte_q, 2)} + 9'h001;
  endproperty
  a_cycles: assert property (p_cycles) else $error("cycle count not count plus one");

  // the window register follows the values that stood one edge earlier
  property p_window;
    aresetn |=>
      custom_b_window_refcycles == ($past(quarter) ? {$past(custom_b_monitor_cycles), 2'b00}
                                                   : {2'b00, $past(custom_b_monitor_cycles)});
  endproperty
  a_window: assert property (p_window) else $error("window not scaled by quarter bit");

  property p_prediv_half;
    do_write && w_strb_q && wr_idx == PREDIV_IDX && w_byte_q[3:0] == PREDIV_ONE_HALF
      && is_mapped(wr_idx, aw_addr_q)
      |-> ##2 prediv_ratio_x2 == 5'h03 && prediv_code_legal;
  endproperty
  a_prediv_half: assert property (p_prediv_half) else $error("code 1010 not 1.5");

  property p_prediv_reserved;
    !(prediv_code <= PREDIV_MAX_INT || prediv_code == PREDIV_ONE_HALF ||
      prediv_code == PREDIV_TWO_HALF)
      |=> !prediv_code_legal && prediv_ratio_x2 == 5'h02;
  endproperty
  a_prediv_reserved: assert property (p_prediv_reserved) else $error("reserved code legal");

  property p_write_resp;
    do_write |=> s_axi_bvalid && (s_axi_bresp == RESP_OKAY) == $past(is_mapped(wr_idx, aw_addr_q));
  endproperty
  a_write_resp: assert property (p_write_resp) else $error("write response wrong");

  property p_read_resp;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid ##0 s_axi_rvalid [*1];
  endproperty
  a_read_resp: assert property (p_read_resp) else $error("read answer late");

endmodule : custom_b_monitor_regs
`default_nettype wire

/* verification/custom_b_monitor_regs_test.sv */
// self-checking bench for the custom-b monitor and predivide register bank.
// assumes the bank is the only slave, driven straight by this bench over axi4-lite.
`timescale 1ns/1ps
`default_nettype none
module custom_b_monitor_regs_test
  import custom_b_regs_pkg::*;
;
  typedef struct {
    logic [7:0]  idx;
    logic [31:0] wdata;
    logic [3:0]  strb;
    logic [7:0]  rd;
    logic [1:0]  resp;
  } row_t;

  logic        aclk;
  logic        aresetn;
  logic [11:0] awaddr;
  logic        awvalid;
  logic        awready;
  logic [31:0] wdata;
  logic [3:0]  wstrb;
  logic        wvalid;
  logic        wready;
  logic [1:0]  bresp;
  logic        bvalid;
  logic        bready;
  logic [11:0] araddr;
  logic        arvalid;
  logic        arready;
  logic [31:0] rdata;
  logic [1:0]  rresp;
  logic        rvalid;
  logic        rready;
  logic [15:0] upper;
  logic [15:0] lower;
  logic [8:0]  cycles;
  logic        quarter;
  logic [10:0] window;
  logic [4:0]  ratio_x2;
  logic        legal;
  row_t        rows [9];
  logic [31:0] d;
  logic [1:0]  r;
  int          errors;
  int          total_checks;

  custom_b_monitor_regs #(.ADDR_W(12)) custom_b_monitor_regs_i (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .custom_b_upper_limit(upper), .custom_b_lower_limit(lower),
    .custom_b_monitor_cycles(cycles), .custom_b_monitor_quarter(quarter),
    .custom_b_window_refcycles(window), .prediv_ratio_x2(ratio_x2),
    .prediv_code_legal(legal)
  );

  ////////////////////////////////////////////////////////////////////////////
  task automatic check_data(input string name, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask : check_data

  task automatic check_resp(input string name, input logic [1:0] exp, input logic [1:0] got);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask : check_resp

  task automatic stop_test;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : stop_test

  // address and data go out together; each is dropped at its own handshake
  task automatic bus_write(input logic [7:0] idx, input logic [31:0] data,
                           input logic [3:0] strb, output logic [1:0] resp);
    resp = 2'h1;
    @(posedge aclk);
    awaddr  <= {2'h0, idx, 2'h0};
    awvalid <= 1'b1;
    wdata   <= data;
    wstrb   <= strb;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    // no cycle count assumed: only the watchdog ends a hung wait
    forever begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid && bready) begin
        resp = bresp;
        break;
      end
    end
    bready <= 1'b0;
  endtask : bus_write

  task automatic bus_read(input logic [7:0] idx, output logic [31:0] data,
                          output logic [1:0] resp);
    resp = 2'h1;
    data = 32'hFFFFFFFF;
    @(posedge aclk);
    araddr  <= {2'h0, idx, 2'h0};
    arvalid <= 1'b1;
    rready  <= 1'b1;
    forever begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid && rready) begin
        data = rdata;
        resp = rresp;
        break;
      end
    end
    rready <= 1'b0;
  endtask : bus_read

  // derived outputs trail the register by up to two edges
  task automatic settle;
    repeat (3) @(posedge aclk);
    #1;
  endtask : settle

  task automatic check_outputs(input logic [15:0] up, input logic [15:0] lo,
                               input logic [8:0] cy, input logic q, input logic [10:0] win);
    check_data("upper limit", 32'(up), 32'(upper));
    check_data("lower limit", 32'(lo), 32'(lower));
    check_data("monitor cycles", 32'(cy), 32'(cycles));
    check_data("quarter", 32'(q), 32'(quarter));
    check_data("window", 32'(win), 32'(window));
  endtask : check_outputs

  function automatic logic [4:0] exp_ratio(input logic [3:0] c);
    if (c <= 4'h7) return 5'(2 * (int'(c) + 1));
    if (c == 4'hA) return 5'h03;
    if (c == 4'hC) return 5'h05;
    return 5'h02;
  endfunction : exp_ratio

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end

  // whole run is well under 2000 cycles
  initial begin : watchdog
    repeat (5000) @(posedge aclk);
    errors++;
    stop_test();
  end

  initial begin
    errors = 0;
    total_checks = 0;
    aresetn = 1'b0;
    awaddr = 12'h000;
    awvalid = 1'b0;
    wdata = 32'h00000000;
    wstrb = 4'h0;
    wvalid = 1'b0;
    bready = 1'b0;
    araddr = 12'h000;
    arvalid = 1'b0;
    rready = 1'b0;
    // reserved register bits and bus bits above the byte both read back as zero
    // an unmapped slot answers decerr; a cleared strobe stores nothing
    rows = '{'{8'h75, 32'h000000A5, 4'hF, 8'hA5, RESP_OKAY},
             '{8'h76, 32'h0000005A, 4'hF, 8'h5A, RESP_OKAY},
             '{8'h77, 32'h00000034, 4'hF, 8'h34, RESP_OKAY},
             '{8'h78, 32'h00000012, 4'hF, 8'h12, RESP_OKAY},
             '{8'h79, 32'h000000FF, 4'hF, 8'hFF, RESP_OKAY},
             '{8'h7A, 32'hFFFFFF01, 4'hF, 8'h01, RESP_OKAY},
             '{8'h7E, 32'hFFFFFF03, 4'hF, 8'h03, RESP_OKAY},
             '{8'h7B, 32'h00000055, 4'hF, 8'h00, RESP_DECERR},
             '{8'h77, 32'h00000099, 4'h0, 8'h34, RESP_OKAY}};
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    #1;
    check_outputs(16'h0000, 16'h0000, 9'h001, 1'b0, 11'h001);
    check_data("ratio after reset", 32'h2, 32'(ratio_x2));
    check_data("legal after reset", 32'h1, 32'(legal));
    foreach (rows[i]) begin
      bus_read(rows[i].idx, d, r);
      check_data("reset read", 32'h0, d);
      check_resp("reset read resp", rows[i].resp, r);
    end
    foreach (rows[i]) begin
      bus_write(rows[i].idx, rows[i].wdata, rows[i].strb, r);
      check_resp("write resp", rows[i].resp, r);
    end
    foreach (rows[i]) begin
      bus_read(rows[i].idx, d, r);
      check_data("read data", 32'(rows[i].rd), d);
      check_resp("read resp", rows[i].resp, r);
    end
    settle();
    check_outputs(16'h1234, 16'h5AA5, 9'h100, 1'b1, 11'h400);
    check_data("ratio", 32'h8, 32'(ratio_x2));
    bus_write(8'h79, 32'h00000009, 4'hF, r);
    bus_write(8'h7A, 32'h00000000, 4'hF, r);
    settle();
    check_outputs(16'h1234, 16'h5AA5, 9'h00A, 1'b0, 11'h00A);
    bus_write(8'h7A, 32'h00000001, 4'hF, r);
    settle();
    check_outputs(16'h1234, 16'h5AA5, 9'h00A, 1'b1, 11'h028);
    bus_write(8'h79, 32'h00000000, 4'hF, r);
    settle();
    check_outputs(16'h1234, 16'h5AA5, 9'h001, 1'b1, 11'h004);
    // codes 1101 and up are never written; 1000, 1001 and 1011 show the fallback
    for (int c = 0; c < 13; c++) begin
      bus_write(8'h7E, 32'(c), 4'hF, r);
      settle();
      check_data("ratio code", 32'(exp_ratio(4'(c))), 32'(ratio_x2));
      check_data("legal code", 32'(c <= 7 || c == 10 || c == 12), 32'(legal));
    end
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    #1;
    check_outputs(16'h0000, 16'h0000, 9'h001, 1'b0, 11'h001);
    check_data("ratio after reset", 32'h2, 32'(ratio_x2));
    check_data("legal after reset", 32'h1, 32'(legal));
    bus_read(8'h78, d, r);
    check_data("read after reset", 32'h0, d);
    stop_test();
  end
endmodule : custom_b_monitor_regs_test
`default_nettype wire
